// *** design/radio_spi_command.sv ***
`timescale 1ns/1ps

// serial side: runs only while the link clock toggles inside a frame
module radio_spi_link (
  // link pins
  input  wire logic       sck,
  input  wire logic       rstn,
  input  wire logic       slave_select_n,
  input  wire logic       mosi,
  // to the command side
  output logic [7:0]      byte_data,
  output logic            byte_toggle,
  output logic [2:0]      bit_count
);
  import radio_spi_pkg::*;
  typedef struct packed {
    logic [2:0] bitcnt;
    logic [6:0] shift;
  } frame_t;
  frame_t fr;
  frame_t next_fr;
  logic   frame_rst_n;
  // select high clears the bit position: every frame begins on a byte
  assign frame_rst_n = rstn & ~slave_select_n;
  assign bit_count   = fr.bitcnt;
  always_comb begin
    next_fr.bitcnt = fr.bitcnt + 3'd1;
    next_fr.shift  = {fr.shift[5:0], mosi};
  end
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end
  // toggle survives the frame so the far side never sees a false edge
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      byte_data   <= 8'h00;
      byte_toggle <= 1'b0;
    end else if (fr.bitcnt == 3'd7) begin
      byte_data   <= {fr.shift, mosi};
      byte_toggle <= ~byte_toggle;
    end
  end
endmodule
module radio_spi_command (
  // system clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RSTN,
  // serial link
  input  wire logic                        SCK,
  input  wire logic                        SLAVE_SELECT_N,
  input  wire logic                        MOSI,
  output logic                             MISO,
  output logic                             MISO_OE_N,
  // radio core state
  input  wire logic                        RADIO_ACTIVE,
  input  wire logic                        TX_BUSY,
  input  wire radio_spi_pkg::radio_events_t EVENTS,
  input  wire logic [2:0]                  RX_PIPE,
  output logic                             RADIO_INTERRUPT_N,
  output logic                             POWER_UP,
  output logic                             PRIMARY_RX,
  // external register map
  output radio_spi_pkg::reg_access_t       REG_ACCESS,
  input  wire logic [7:0]                  REG_RDATA,
  // transmit payload port
  input  wire logic [2:0]                  TX_SEL_PIPE,
  input  wire logic [5:0]                  TX_PIPE_LOST,
  input  wire logic [4:0]                  TX_RD_INDEX,
  input  wire logic                        TX_DONE,
  output logic                             TX_AVAIL,
  output logic                             TX_STALLED,
  output radio_spi_pkg::tx_info_t          TX_INFO,
  output logic [7:0]                       TX_RD_DATA,
  // receive payload port
  input  wire radio_spi_pkg::rx_write_t    RX_WRITE,
  output logic                             RX_FULL
);
  import radio_spi_pkg::*;
  typedef struct packed {
    logic [2:0]         csn_sync;
    logic [2:0]         tog_sync;
    cmd_state_t         st;
    logic [4:0]         addr;
    logic [5:0]         idx;
    logic               rd_pend;
    logic [7:0]         out_byte;
    logic [7:0]         cfg;
    logic [2:0]         flags;
    logic [2:0]         pipe;
    logic               irq_n;
    logic               reuse;
    logic [1:0]         tx_count;
    logic [1:0]         rx_count;
    logic [4:0]         rx_fill;
    reg_access_t        reg_acc;
    slot_t [DEPTH-1:0]  tx;
    slot_t [DEPTH-1:0]  rx;
  } state_t;
  state_t     s;
  state_t     n;
  logic [7:0] link_byte;
  logic       link_toggle;
  logic [2:0] link_bitcnt;
  logic       frame_start;
  logic       frame_end;
  logic       byte_ev;
  logic [2:0] stat_clr;
  logic       tx_full;
  logic       rx_full;
  logic [7:0] status_byte;
  logic [7:0] fifo_status;
  logic [7:0] reg_value;
  logic [1:0] tx_sel;
  logic       tx_avail;
  logic       tx_stalled;
  radio_spi_link link (
    .sck            (SCK),
    .rstn           (RSTN),
    .slave_select_n (SLAVE_SELECT_N),
    .mosi           (MOSI),
    .byte_data      (link_byte),
    .byte_toggle    (link_toggle),
    .bit_count      (link_bitcnt)
  );
  // sync stage 0 feeds only stage 1; edges are taken from stages 1 and 2
  assign frame_start = s.csn_sync[2] & ~s.csn_sync[1];
  assign frame_end   = ~s.csn_sync[2] & s.csn_sync[1];
  assign byte_ev     = (s.tog_sync[2] ^ s.tog_sync[1]) & ~s.csn_sync[1];
  assign tx_full = (s.tx_count == FIFO_LEVELS);
  assign rx_full = (s.rx_count == FIFO_LEVELS);
  assign status_byte = {1'b0, s.flags, s.pipe, tx_full};
  assign fifo_status = {1'b0, s.reuse, tx_full, (s.tx_count == 2'd0),
                        2'b00, rx_full, (s.rx_count == 2'd0)};
  // write-one-to-clear on the status register, first data byte only
  assign stat_clr = (byte_ev && s.st == ST_REG_WR && s.addr == ADDR_STATUS
                     && s.idx == 6'd0) ? link_byte[6:4] : 3'b000;
  always_comb begin
    case (s.addr)
      ADDR_CONFIG:      reg_value = (s.idx == 6'd0) ? s.cfg : 8'h00;
      ADDR_STATUS:      reg_value = (s.idx == 6'd0) ? status_byte : 8'h00;
      ADDR_FIFO_STATUS: reg_value = (s.idx == 6'd0) ? fifo_status : 8'h00;
      default:          reg_value = REG_RDATA;
    endcase
  end
  // receiver role: oldest entry of the asked pipe; other pipes may overtake
  always_comb begin
    tx_sel     = 2'd0;
    tx_avail   = 1'b0;
    tx_stalled = (s.tx_count != 2'd0) && s.cfg[CFG_PRIM_RX];
    for (int k = DEPTH - 1; k >= 0; k--) begin
      if (2'(k) < s.tx_count) begin
        if (!TX_PIPE_LOST[s.tx[k].pipe]) begin
          tx_stalled = 1'b0;
        end
        if (!s.cfg[CFG_PRIM_RX]) begin
          tx_sel   = 2'd0;
          tx_avail = 1'b1;
        end else if (s.tx[k].pipe == TX_SEL_PIPE &&
                     !TX_PIPE_LOST[TX_SEL_PIPE]) begin
          tx_sel   = 2'(k);
          tx_avail = 1'b1;
        end
      end
    end
  end
  always_comb begin
    n = s;
    n.csn_sync   = {s.csn_sync[1:0], SLAVE_SELECT_N};
    n.tog_sync   = {s.tog_sync[1:0], link_toggle};
    n.reg_acc.we = 1'b0;
    n.rd_pend    = 1'b0;
    // an event in the clearing cycle stays set
    n.flags = (s.flags & ~stat_clr) | EVENTS;
    n.irq_n = ~|(n.flags & ~s.cfg[CFG_MASK_HI:CFG_MASK_LO]);
    if (s.irq_n && !n.irq_n) begin
      n.pipe = RX_PIPE;
    end
    // delivered payload leaves unless reuse is set; a retransmit limit never pops the head
    if (TX_DONE && tx_avail && !s.reuse) begin
      for (int k = 0; k < DEPTH - 1; k++) begin
        if (k >= int'(tx_sel)) begin
          n.tx[k] = s.tx[k+1];
        end
      end
      n.tx_count = s.tx_count - 2'd1;
    end
    if (frame_end && s.st == ST_RX_RD && s.idx != 6'd0 &&
        s.rx_count != 2'd0) begin
      for (int k = 0; k < DEPTH - 1; k++) begin
        n.rx[k] = s.rx[k+1];
      end
      n.rx_count = s.rx_count - 2'd1;
    end
    // radio core fills the slot just above the stored entries
    if (RX_WRITE.valid && n.rx_count != FIFO_LEVELS) begin
      n.rx[n.rx_count].data[s.rx_fill] = RX_WRITE.data;
      if (RX_WRITE.last) begin
        n.rx[n.rx_count].width = {1'b0, s.rx_fill} + 6'd1;
        n.rx[n.rx_count].pipe  = RX_WRITE.pipe;
        n.rx_count = n.rx_count + 2'd1;
        n.rx_fill  = 5'd0;
      end else if (s.rx_fill != 5'h1F) begin
        n.rx_fill = s.rx_fill + 5'd1;
      end
    end
    if (s.rd_pend) begin
      n.out_byte = reg_value;
    end
    if (frame_start) begin
      n.st       = ST_CMD;
      n.out_byte = status_byte;
      n.idx      = 6'd0;
    end
    if (frame_end) begin
      if (s.st == ST_TX_WR && s.idx != 6'd0) begin
        n.tx[n.tx_count].width = s.idx;
        n.tx_count = n.tx_count + 2'd1;
      end
      n.st = ST_IDLE;
    end
    if (byte_ev) begin
      case (s.st)
        ST_CMD: begin
          n.idx = 6'd0;
          n.st  = ST_IGNORE;
          if (link_byte[7:5] == OP_REG_READ) begin
            n.st      = ST_REG_RD;
            n.addr    = link_byte[4:0];
            n.rd_pend = 1'b1;
            n.reg_acc.addr  = link_byte[4:0];
            n.reg_acc.index = 3'd0;
          end else if (link_byte[7:5] == OP_REG_WRITE) begin
            n.st   = ST_REG_WR;
            n.addr = link_byte[4:0];
          end else if (link_byte == CMD_RX_PAYLOAD) begin
            n.st       = ST_RX_RD;
            n.out_byte = (s.rx_count != 2'd0) ? s.rx[0].data[0] : 8'h00;
          end else if (link_byte == CMD_RX_WIDTH) begin
            n.st       = ST_WIDTH;
            n.out_byte = (s.rx_count != 2'd0) ? {2'b00, s.rx[0].width}
                                              : 8'h00;
          end else if (link_byte == CMD_TX_PAYLOAD ||
                       link_byte == CMD_TX_NOACK ||
                       (link_byte[7:3] == OP_ACK_PAYLOAD &&
                        link_byte[2:0] <= ACK_PIPE_MAX)) begin
            if (link_byte == CMD_TX_PAYLOAD) begin
              n.reuse = 1'b0;
            end
            if (n.tx_count != FIFO_LEVELS) begin
              n.st = ST_TX_WR;
              n.tx[n.tx_count].noack = (link_byte == CMD_TX_NOACK);
              n.tx[n.tx_count].pipe  =
                (link_byte[7:3] == OP_ACK_PAYLOAD) ? link_byte[2:0] : 3'h0;
            end
          end else if (link_byte == CMD_FLUSH_TX) begin
            n.tx_count = 2'd0;
            n.reuse    = 1'b0;
          end else if (link_byte == CMD_FLUSH_RX) begin
            n.rx_count = 2'd0;
          end else if (link_byte == CMD_REUSE && !TX_BUSY) begin
            n.reuse = 1'b1;
          end
        end
        ST_REG_RD: begin
          if (s.idx[2:0] != REG_LAST_INDEX) begin
            n.idx     = s.idx + 6'd1;
            n.rd_pend = 1'b1;
            n.reg_acc.index = s.idx[2:0] + 3'd1;
          end else begin
            n.st = ST_IGNORE;
          end
        end
        ST_REG_WR: begin
          // each byte lands at once, so a short write keeps higher bytes
          if (!RADIO_ACTIVE && s.addr != ADDR_STATUS &&
              s.addr != ADDR_FIFO_STATUS) begin
            n.reg_acc = '{we: s.addr != ADDR_CONFIG, addr: s.addr,
                          index: s.idx[2:0], wdata: link_byte};
            if (s.addr == ADDR_CONFIG && s.idx == 6'd0) begin
              n.cfg = link_byte;
            end
          end
          n.idx = s.idx + 6'd1;
          if (s.idx[2:0] == REG_LAST_INDEX) begin
            n.st = ST_IGNORE;
          end
        end
        ST_RX_RD: begin
          if (s.idx != PAYLOAD_LIMIT) begin
            n.idx = s.idx + 6'd1;
            n.out_byte = (s.idx != PAYLOAD_LAST && s.rx_count != 2'd0)
                         ? s.rx[0].data[s.idx[4:0] + 5'd1] : 8'h00;
          end
        end
        ST_TX_WR: begin
          if (s.idx != PAYLOAD_LIMIT) begin
            n.tx[n.tx_count].data[s.idx[4:0]] = link_byte;
            n.idx = s.idx + 6'd1;
          end
        end
        ST_WIDTH: begin
          n.st = ST_IGNORE;
        end
        ST_IDLE, ST_IGNORE: begin
          n.st = s.st;
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s          <= '0;
      s.csn_sync <= 3'b111;
      s.st       <= ST_IDLE;
      s.cfg      <= CONFIG_RESET;
      s.pipe     <= PIPE_EMPTY;
      s.irq_n    <= 1'b1;
    end else begin
      s <= n;
    end
  end
  // shift bits come straight from the held byte, updated between bytes
  assign MISO      = s.out_byte[3'd7 - link_bitcnt];
  assign MISO_OE_N = SLAVE_SELECT_N;
  assign RADIO_INTERRUPT_N = s.irq_n;
  assign POWER_UP          = s.cfg[CFG_POWER_UP];
  assign PRIMARY_RX        = s.cfg[CFG_PRIM_RX];
  assign REG_ACCESS        = s.reg_acc;
  assign TX_AVAIL          = tx_avail;
  assign TX_STALLED        = tx_stalled;
  assign TX_INFO           = '{width: s.tx[tx_sel].width,
                               pipe:  s.tx[tx_sel].pipe,
                               noack: s.tx[tx_sel].noack};
  assign TX_RD_DATA        = s.tx[tx_sel].data[TX_RD_INDEX];
  assign RX_FULL           = rx_full;
endmodule

// *** shared/radio_spi_pkg.sv ***
package radio_spi_pkg;

  localparam int PAYLOAD_BYTES = 32;
  localparam int DEPTH         = 3;

  localparam logic [1:0] FIFO_LEVELS    = 2'd3;
  localparam logic [2:0] REG_LAST_INDEX = 3'd4;
  localparam logic [5:0] PAYLOAD_LAST   = 6'd31;
  localparam logic [5:0] PAYLOAD_LIMIT  = 6'd32;

  // command words and opcode fields
  localparam logic [2:0] OP_REG_READ    = 3'h0;
  localparam logic [2:0] OP_REG_WRITE   = 3'h1;
  localparam logic [4:0] OP_ACK_PAYLOAD = 5'h15;
  localparam logic [2:0] ACK_PIPE_MAX   = 3'h5;
  localparam logic [7:0] CMD_RX_WIDTH   = 8'h60;
  localparam logic [7:0] CMD_RX_PAYLOAD = 8'h61;
  localparam logic [7:0] CMD_TX_PAYLOAD = 8'hA0;
  localparam logic [7:0] CMD_TX_NOACK   = 8'hB0;
  localparam logic [7:0] CMD_FLUSH_TX   = 8'hE1;
  localparam logic [7:0] CMD_FLUSH_RX   = 8'hE2;
  localparam logic [7:0] CMD_REUSE      = 8'hE3;
  localparam logic [7:0] CMD_NOP        = 8'hFF;

  // register addresses kept inside this block
  localparam logic [4:0] ADDR_CONFIG      = 5'h00;
  localparam logic [4:0] ADDR_STATUS      = 5'h1E;
  localparam logic [4:0] ADDR_FIFO_STATUS = 5'h1F;

  // configuration fields: mask bits 6:4 line up with status flags 6:4
  localparam logic [7:0] CONFIG_RESET = 8'h08;
  localparam int CFG_MASK_HI  = 6;
  localparam int CFG_MASK_LO  = 4;
  localparam int CFG_POWER_UP = 1;
  localparam int CFG_PRIM_RX  = 0;

  localparam logic [2:0] PIPE_EMPTY = 3'h7;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_CMD    = 8'h02,
    ST_REG_RD = 8'h04,
    ST_REG_WR = 8'h08,
    ST_RX_RD  = 8'h10,
    ST_TX_WR  = 8'h20,
    ST_WIDTH  = 8'h40,
    ST_IGNORE = 8'h80
  } cmd_state_t;

  typedef struct packed {
    logic [PAYLOAD_BYTES-1:0][7:0] data;
    logic [5:0]                    width;
    logic [2:0]                    pipe;
    logic                          noack;
  } slot_t;

  typedef struct packed {
    logic [5:0] width;
    logic [2:0] pipe;
    logic       noack;
  } tx_info_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic [2:0] pipe;
  } rx_write_t;

  // order matches status bits 6:4
  typedef struct packed {
    logic data_received;
    logic data_sent;
    logic retransmit_limit;
  } radio_events_t;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [2:0] index;
    logic [7:0] wdata;
  } reg_access_t;

endpackage

// *** tb/radio_spi_checker_asserts.sv ***
`timescale 1ns/1ps
module radio_spi_checker
  import radio_spi_pkg::*;
(
  // clock and reset
  input wire logic                         CLK,
  input wire logic                         RSTN,
  // link and radio side
  input wire logic                         SLAVE_SELECT_N,
  input wire logic                         MISO_OE_N,
  input wire logic                         RADIO_ACTIVE,
  input wire radio_spi_pkg::radio_events_t EVENTS,
  input wire logic                         RADIO_INTERRUPT_N,
  input wire logic                         PRIMARY_RX,
  // payload and register ports
  input wire radio_spi_pkg::reg_access_t   REG_ACCESS,
  input wire logic                         TX_DONE,
  input wire logic                         TX_AVAIL,
  input wire logic                         TX_STALLED,
  input wire radio_spi_pkg::tx_info_t      TX_INFO,
  input wire radio_spi_pkg::rx_write_t     RX_WRITE,
  input wire logic                         RX_FULL
);
  // cycles since select was last seen low; saturates
  logic [3:0] idle_cnt;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      idle_cnt <= 4'h0;
    end else if (!SLAVE_SELECT_N) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hF) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_oe_select: assert property (MISO_OE_N == SLAVE_SELECT_N)
    else $error("output enable does not follow select");
  // a mask write inside a frame may also expose a pending flag
  a_irq_cause: assert property ($fell(RADIO_INTERRUPT_N) |->
    $past(EVENTS) != 3'b000 || !$past(SLAVE_SELECT_N))
    else $error("interrupt fell without a cause");
  a_irq_release: assert property ($rose(RADIO_INTERRUPT_N) |->
    !$past(SLAVE_SELECT_N))
    else $error("interrupt released outside a frame");
  a_write_idle: assert property (REG_ACCESS.we |-> !$past(RADIO_ACTIVE))
    else $error("register write while radio active");
  a_write_frame: assert property (REG_ACCESS.we |-> idle_cnt == 4'h0)
    else $error("register write outside a frame");
  a_write_index: assert property (REG_ACCESS.we |->
    REG_ACCESS.index <= REG_LAST_INDEX)
    else $error("register write beyond five bytes");
  a_stall_role: assert property (TX_STALLED |->
    PRIMARY_RX && !TX_AVAIL)
    else $error("stall outside receiver role");
  a_rx_count: assert property ($rose(RX_FULL) |->
    $past(RX_WRITE.last) || $past(RX_WRITE.last, 2))
    else $error("receive fifo filled without a push");
  a_head_stays: assert property (EVENTS.retransmit_limit &&
    !TX_DONE && !$past(TX_DONE) && !PRIMARY_RX && idle_cnt > 4'h6
    |=> $stable(TX_INFO))
    else $error("head payload moved on retransmit limit");

  c_reg_write: cover property (REG_ACCESS.we);
  c_irq_low: cover property ($fell(RADIO_INTERRUPT_N));
  c_rx_full: cover property ($rose(RX_FULL));
  c_stalled: cover property (TX_STALLED);
endmodule

// *** tb/spi_master_model.sv ***
`timescale 1ns/1ps
// serial controller: its clock runs only inside a byte
module spi_master_model (
  // link pins
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end

  // gaps exceed what the byte handover into the system clock needs
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] v;
    rx = {};
    ss_n = 1'b0;
    #437;
    foreach (tx[i]) begin
      for (int b = 7; b >= 0; b--) begin
        mosi = tx[i][b];
        #7.5;
        v[b] = miso;
        sck = 1'b1;
        #7.5;
        sck = 1'b0;
      end
      // idle line shows the inverse, never a stale level
      mosi = ~mosi;
      rx.push_back(v);
      #613;
    end
    ss_n = 1'b1;
    #537;
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import radio_spi_pkg::*;
  localparam int LIMIT = 20000;

  logic          clk = 1'b0, rstn = 1'b0, sck, ss_n, mosi, miso, oe_n;
  logic          radio_active = 1'b0, tx_busy = 1'b0, tx_done = 1'b0;
  logic          irq_n, power_up, primary_rx, tx_avail, tx_stalled, rx_full;
  logic [2:0]    rx_pipe = 3'h0, tx_sel_pipe = 3'h0;
  logic [5:0]    tx_pipe_lost = 6'h00;
  logic [4:0]    tx_rd_index = 5'h00;
  logic [7:0]    reg_rdata, tx_rd_data;
  radio_events_t events = 3'b000;
  rx_write_t     rx_write = '0;
  reg_access_t   reg_access;
  tx_info_t      tx_info;
  logic [7:0]    rsp[$];
  reg_access_t   we_q[$];
  int            fails = 0, samples_checked = 0, cycles = 0;

  radio_spi_command dut_u (
    .CLK(clk), .RSTN(rstn), .SCK(sck), .SLAVE_SELECT_N(ss_n),
    .MOSI(mosi), .MISO(miso), .MISO_OE_N(oe_n),
    .RADIO_ACTIVE(radio_active), .TX_BUSY(tx_busy), .EVENTS(events),
    .RX_PIPE(rx_pipe), .RADIO_INTERRUPT_N(irq_n), .POWER_UP(power_up),
    .PRIMARY_RX(primary_rx), .REG_ACCESS(reg_access),
    .REG_RDATA(reg_rdata), .TX_SEL_PIPE(tx_sel_pipe),
    .TX_PIPE_LOST(tx_pipe_lost), .TX_RD_INDEX(tx_rd_index),
    .TX_DONE(tx_done), .TX_AVAIL(tx_avail), .TX_STALLED(tx_stalled),
    .TX_INFO(tx_info), .TX_RD_DATA(tx_rd_data), .RX_WRITE(rx_write),
    .RX_FULL(rx_full));
  spi_master_model mst_u (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));

  // outside register map: data names its own address and byte
  assign reg_rdata = {reg_access.addr[3:0], 1'b0, reg_access.index};
  always #50 clk = ~clk;
  always @(posedge clk) if (reg_access.we) we_q.push_back(reg_access);
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("ERROR %0t run timed out", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] tx[$]);
    mst_u.frame(tx, rsp);
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [2:0] ev, input logic done);
    repeat (8) @(posedge clk);
    events <= ev;
    tx_done <= done;
    @(posedge clk);
    events <= 3'b000;
    tx_done <= 1'b0;
    settle();
  endtask
  task automatic push(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    rx_write <= '{1'b1, a, 1'b0, 3'h2};
    @(posedge clk);
    rx_write <= '{1'b1, b, 1'b1, 3'h2};
    @(posedge clk);
    rx_write <= '0;
  endtask

  task automatic t_reset();
    chk_bit(irq_n, 1'b1);
    xfer({CMD_NOP});
    chk_byte(rsp[0], 8'h0E);
    xfer({8'h00, 8'h00});
    chk_byte(rsp[1], 8'h08);
    xfer({8'h1F, 8'h00});
    chk_byte(rsp[1], 8'h11);
    xfer({CMD_NOP, 8'h20, 8'h5A});
    xfer({8'h00, 8'h00});
    chk_byte(rsp[1], 8'h08);
    $display("reset test done");
  endtask
  task automatic t_config();
    xfer({8'h20, 8'h5A});
    chk_bit(power_up, 1'b1);
    @(posedge clk);
    radio_active <= 1'b1;
    xfer({8'h20, 8'h08});
    xfer({8'h00, 8'h00});
    chk_byte(rsp[1], 8'h5A);
    @(posedge clk);
    radio_active <= 1'b0;
    xfer({8'h20, 8'h08});
    chk_bit(power_up, 1'b0);
    $display("config test done");
  endtask
  task automatic t_irq();
    xfer({8'h20, 8'h28});
    pulse(3'b010, 1'b0);
    chk_bit(irq_n, 1'b1);
    @(posedge clk);
    rx_pipe <= 3'h3;
    pulse(3'b100, 1'b0);
    chk_bit(irq_n, 1'b0);
    xfer({CMD_NOP});
    chk_byte(rsp[0], 8'h66);
    xfer({8'h3E, 8'h70});
    chk_bit(irq_n, 1'b1);
    xfer({8'h20, 8'h08});
    $display("interrupt test done");
  endtask
  task automatic t_ext();
    we_q = {};
    xfer({8'h25, 8'h11, 8'h22});
    chk_byte(8'(we_q.size()), 8'h02);
    foreach (we_q[i]) begin
      chk_byte(we_q[i].wdata, 8'(8'h11 * (i + 1)));
      chk_byte({we_q[i].addr, we_q[i].index}, {5'h05, 3'(i)});
    end
    xfer({8'h05, 8'h00, 8'h00});
    chk_byte(rsp[1], 8'h50);
    chk_byte(rsp[2], 8'h51);
    $display("register test done");
  endtask
  task automatic t_tx();
    xfer({CMD_TX_PAYLOAD, 8'hAA, 8'hBB, 8'hCC});
    chk_byte({2'b00, tx_info.width}, 8'h03);
    @(posedge clk);
    tx_rd_index <= 5'h01;
    settle();
    chk_byte(tx_rd_data, 8'hBB);
    xfer({CMD_TX_NOACK, 8'h44});
    xfer({CMD_TX_PAYLOAD, 8'h55, 8'h66});
    xfer({8'h1F, 8'h00});
    chk_byte(rsp[1], 8'h21);
    pulse(3'b000, 1'b1);
    chk_bit(tx_info.noack, 1'b1);
    @(posedge clk);
    tx_busy <= 1'b1;
    xfer({CMD_REUSE});
    xfer({8'h1F, 8'h00});
    chk_byte(rsp[1], 8'h01);
    @(posedge clk);
    tx_busy <= 1'b0;
    xfer({CMD_REUSE});
    xfer({8'h1F, 8'h00});
    chk_byte(rsp[1], 8'h41);
    pulse(3'b000, 1'b1);
    pulse(3'b001, 1'b0);
    chk_byte({2'b00, tx_info.width}, 8'h01);
    xfer({CMD_FLUSH_TX});
    xfer({8'h1F, 8'h00});
    chk_byte(rsp[1], 8'h11);
    xfer({8'h3E, 8'h70});
    $display("transmit test done");
  endtask
  task automatic t_rx();
    for (int i = 0; i < 3; i++) begin
      push(8'h10 + 8'(i), 8'h20 + 8'(i));
    end
    settle();
    chk_bit(rx_full, 1'b1);
    xfer({CMD_RX_WIDTH, 8'h00});
    chk_byte(rsp[1], 8'h02);
    xfer({CMD_RX_PAYLOAD, 8'h00, 8'h00});
    chk_byte(rsp[2], 8'h20);
    chk_bit(rx_full, 1'b0);
    xfer({CMD_RX_PAYLOAD, 8'h00});
    chk_byte(rsp[1], 8'h11);
    // flush drops the one entry left: both fifos read empty
    xfer({CMD_FLUSH_RX});
    xfer({8'h1F, 8'h00});
    chk_byte(rsp[1], 8'h11);
    $display("receive test done");
  endtask
  task automatic t_ack();
    xfer({8'h20, 8'h0B});
    @(posedge clk);
    tx_sel_pipe <= 3'h2;
    xfer({8'hAA, 8'h77});
    xfer({8'hAA, 8'h88, 8'h99});
    chk_byte({5'h00, tx_info.pipe}, 8'h02);
    chk_bit(tx_avail, 1'b1);
    chk_bit(primary_rx, 1'b1);
    pulse(3'b000, 1'b1);
    chk_byte({2'b00, tx_info.width}, 8'h02);
    @(posedge clk);
    tx_pipe_lost <= 6'h04;
    settle();
    chk_bit(tx_stalled, 1'b1);
    xfer({CMD_FLUSH_TX});
    chk_bit(tx_stalled, 1'b0);
    @(posedge clk);
    tx_pipe_lost <= 6'h00;
    xfer({8'h20, 8'h08});
    $display("ack test done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_config();
    t_irq();
    t_ext();
    t_tx();
    t_rx();
    t_ack();
    complete_run();
  end
endmodule

bind radio_spi_command radio_spi_checker chk_u (
  .CLK(CLK), .RSTN(RSTN), .SLAVE_SELECT_N(SLAVE_SELECT_N),
  .MISO_OE_N(MISO_OE_N), .RADIO_ACTIVE(RADIO_ACTIVE), .EVENTS(EVENTS),
  .RADIO_INTERRUPT_N(RADIO_INTERRUPT_N), .PRIMARY_RX(PRIMARY_RX),
  .REG_ACCESS(REG_ACCESS), .TX_DONE(TX_DONE), .TX_AVAIL(TX_AVAIL),
  .TX_STALLED(TX_STALLED), .TX_INFO(TX_INFO), .RX_WRITE(RX_WRITE),
  .RX_FULL(RX_FULL));
